// ### csr_pkg.sv
// Shared constants and types for the charger status reporter link
package csr_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Link timing in nanoseconds
    localparam int REQ_LO_MIN_NS    = 200;
    localparam int REQ_LO_MAX_NS    = 20000;
    localparam int REPORT_DELAY_NS  = 10000;
    localparam int PULSE_PERIOD_NS  = 2000;
    localparam int PULSE_LO_NS      = 1000;
    localparam int HOST_STROBE_NS   = 500;
    localparam int GAP_PERIODS      = 4;
    localparam int FLASH_HALF_NS    = 1000000;

    // Derived cycle counts
    localparam logic [11:0] REQ_LO_MIN_CYC =
        12'((REQ_LO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] REQ_LO_MAX_CYC =
        12'(REQ_LO_MAX_NS / CLK_PERIOD_NS);
    localparam logic [11:0] REPORT_DELAY_CYC =
        12'(REPORT_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_PERIOD_CYC =
        12'(PULSE_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_LO_CYC =
        12'(PULSE_LO_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PULSE_HI_CYC = PULSE_PERIOD_CYC - PULSE_LO_CYC;
    localparam logic [11:0] HOST_STROBE_CYC =
        12'((HOST_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] HOST_GAP_CYC =
        12'((REPORT_DELAY_NS + GAP_PERIODS * PULSE_PERIOD_NS)
            / CLK_PERIOD_NS);
    localparam logic [16:0] FLASH_HALF_CYC =
        17'(FLASH_HALF_NS / CLK_PERIOD_NS);

    // Report pulse counts
    localparam logic [4:0] CODE_DIE_OT     = 5'h01;
    localparam logic [4:0] CODE_BATT_TEMP  = 5'h02;
    localparam logic [4:0] CODE_OVER_VOLT  = 5'h03;
    localparam logic [4:0] CODE_HIGH_BASE  = 5'h0d;
    localparam logic [4:0] CODE_LOW_BASE   = 5'h12;
    localparam logic [4:0] CODE_REPORT_ERR = 5'h17;

    // Charge phase reported by the analog control loop
    typedef enum logic [2:0] {
        CHG_CONDITION = 3'h0,
        CHG_REDUCE_CC = 3'h1,
        CHG_CONST_CUR = 3'h2,
        CHG_CONST_VLT = 3'h3,
        CHG_END       = 3'h4
    } csr_chg_t;

    typedef enum logic [2:0] {
        DEV_IDLE  = 3'h0,
        DEV_REQ   = 3'h1,
        DEV_ABORT = 3'h2,
        DEV_DELAY = 3'h3,
        DEV_LO    = 3'h4,
        DEV_HI    = 3'h5
    } csr_dev_st_t;

    typedef enum logic [1:0] {
        HST_IDLE   = 2'h0,
        HST_STROBE = 2'h1,
        HST_LISTEN = 2'h2
    } csr_hst_st_t;

endpackage

// ### csr_link_if.sv
// Single-wire open-drain report line shared by device and host
`timescale 1ns/1ps
interface csr_link_if;
    logic dev_o;
    logic dev_oe;
    logic host_o;
    logic host_oe;
    logic line;

    // Wired-AND with external pull-up: high unless a party sinks it
    assign line = !((dev_oe && !dev_o) || (host_oe && !host_o));

    modport dev  (output dev_o, output dev_oe, input line);
    modport host (output host_o, output host_oe, input line);
endinterface

// ### csr_device.sv
// Device end: status indicators and pulse-count report responder
//
// Behaviour
// - Indicators only sink to ground or float
// - Disabled or low supply: both indicators off
// - Enabled, no battery, no fault: both indicators flash together
// - Charging A, done B, fault both
// - Line active low, parties only pull low
// - Host strobe answered by counted low pulses
// - Host strobe low at least 200 ns; the device does not check this and answers a shorter strobe too
// - Host strobe shorter than maximum pulse time
// - After strobe rising edge, wait, then reply
// - Reply pulses at fixed repetition period
// - Counts 1-3 faults, 4-12 never sent
// - High setting: counts 13-17 charge states
// - Low setting: counts 18-22, 23 error
// - Over-voltage: fault indication and fault code
// - Enable low: sleep, resume on re-enable
`timescale 1ns/1ps
module csr_device #(
    parameter logic [16:0] FLASH_HALF_CYC = csr_pkg::FLASH_HALF_CYC
) (
    // Clock and reset
    input  wire logic     ref_clk,
    input  wire logic     rst,
    // Report line
    csr_link_if.dev       link,
    // Charger state inputs
    input  wire logic     charge_en,
    input  wire logic     supply_ok,
    input  wire logic     battery_present,
    input  wire logic     high_current_setting,
    input  wire logic     die_overtemp,
    input  wire logic     batt_temp_fault,
    input  wire logic     over_voltage,
    input  wire logic [2:0] charge_state,
    // Open-drain indicators, sink when enable is high
    output logic          indicator_out_a_o,
    output logic          indicator_out_a_oe,
    output logic          indicator_out_b_o,
    output logic          indicator_out_b_oe,
    // Monitor
    output logic          report_busy
);

    typedef struct packed {
        csr_pkg::csr_dev_st_t st;
        logic [11:0]          cnt;
        logic [16:0]          flash_cnt;
        logic                 flash_on;
        logic                 line_q;
        logic [4:0]           num;
        logic [4:0]           sent;
        logic                 pull;
        logic                 ind_a;
        logic                 ind_b;
        logic                 busy;
    } csr_dev_state_t;

    csr_dev_state_t s_q;
    csr_dev_state_t s_d;

    logic fault;
    logic rise;
    logic fall;

    // Pulse count for the present charger condition
    function automatic logic [4:0] report_code(
        input logic       ot,
        input logic       bt,
        input logic       ov,
        input logic       en,
        input logic       sup,
        input logic       hi,
        input logic [2:0] ph
    );
        logic [4:0] base;
        base = hi ? csr_pkg::CODE_HIGH_BASE : csr_pkg::CODE_LOW_BASE;
        if (ot) begin
            report_code = csr_pkg::CODE_DIE_OT;
        end else if (bt) begin
            report_code = csr_pkg::CODE_BATT_TEMP;
        end else if (ov) begin
            report_code = csr_pkg::CODE_OVER_VOLT;
        end else if (!en || !sup || ph > 3'(csr_pkg::CHG_END)) begin
            report_code = csr_pkg::CODE_REPORT_ERR;
        end else begin
            report_code = base + {2'h0, ph};
        end
    endfunction

    assign fault = die_overtemp || batt_temp_fault || over_voltage;
    assign rise  = link.line && !s_q.line_q;
    assign fall  = !link.line && s_q.line_q;

    always_comb begin
        s_d        = s_q;
        s_d.line_q = link.line;

        // Flash timebase runs only while no battery is seen
        if (s_q.flash_cnt >= FLASH_HALF_CYC - 17'h00001) begin
            s_d.flash_cnt = 17'h00000;
            s_d.flash_on  = !s_q.flash_on;
        end else begin
            s_d.flash_cnt = s_q.flash_cnt + 17'h00001;
        end

        // Indicator pattern, sleep and supply override all else
        if (!charge_en || !supply_ok) begin
            s_d.ind_a     = 1'b0;
            s_d.ind_b     = 1'b0;
            s_d.flash_cnt = 17'h00000;
            s_d.flash_on  = 1'b0;
        end else if (fault) begin
            s_d.ind_a = 1'b1;
            s_d.ind_b = 1'b1;
        end else if (!battery_present) begin
            s_d.ind_a = s_q.flash_on;
            s_d.ind_b = s_q.flash_on;
        end else if (charge_state == 3'(csr_pkg::CHG_END)) begin
            s_d.ind_a = 1'b0;
            s_d.ind_b = 1'b1;
        end else begin
            s_d.ind_a = 1'b1;
            s_d.ind_b = 1'b0;
        end
        if (battery_present || fault || !charge_en || !supply_ok) begin
            s_d.flash_cnt = 17'h00000;
            s_d.flash_on  = 1'b0;
        end

        // Report responder
        unique case (s_q.st)
            csr_pkg::DEV_IDLE: begin
                s_d.busy = 1'b0;
                if (fall) begin
                    s_d.st   = csr_pkg::DEV_REQ;
                    s_d.cnt  = 12'h000;
                    s_d.busy = 1'b1;
                end
            end
            csr_pkg::DEV_REQ: begin
                if (rise) begin
                    s_d.st  = csr_pkg::DEV_DELAY;
                    s_d.cnt = 12'h000;
                end else if (s_q.cnt >= csr_pkg::REQ_LO_MAX_CYC) begin
                    // Overlong strobe is dropped without a reply
                    s_d.st = csr_pkg::DEV_ABORT;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            csr_pkg::DEV_ABORT: begin
                if (link.line) begin
                    s_d.st   = csr_pkg::DEV_IDLE;
                    s_d.busy = 1'b0;
                end
            end
            csr_pkg::DEV_DELAY: begin
                if (s_q.cnt >= csr_pkg::REPORT_DELAY_CYC - 12'h001) begin
                    s_d.st   = csr_pkg::DEV_LO;
                    s_d.cnt  = 12'h000;
                    s_d.sent = 5'h00;
                    s_d.pull = 1'b1;
                    s_d.num  = report_code(die_overtemp, batt_temp_fault,
                                           over_voltage, charge_en,
                                           supply_ok, high_current_setting,
                                           charge_state);
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            csr_pkg::DEV_LO: begin
                // Line is ignored here and in the high phase
                if (s_q.cnt >= csr_pkg::PULSE_LO_CYC - 12'h001) begin
                    s_d.st   = csr_pkg::DEV_HI;
                    s_d.cnt  = 12'h000;
                    s_d.pull = 1'b0;
                    s_d.sent = s_q.sent + 5'h01;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            csr_pkg::DEV_HI: begin
                if (s_q.cnt >= csr_pkg::PULSE_HI_CYC - 12'h001) begin
                    s_d.cnt = 12'h000;
                    if (s_q.sent == s_q.num) begin
                        s_d.st   = csr_pkg::DEV_IDLE;
                        s_d.busy = 1'b0;
                    end else begin
                        s_d.st   = csr_pkg::DEV_LO;
                        s_d.pull = 1'b1;
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            default: begin
                s_d.st   = csr_pkg::DEV_IDLE;
                s_d.pull = 1'b0;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Open-drain drive: data is always low, enable sinks
    assign link.dev_o         = 1'b0;
    assign link.dev_oe        = s_q.pull;
    assign indicator_out_a_o  = 1'b0;
    assign indicator_out_a_oe = s_q.ind_a;
    assign indicator_out_b_o  = 1'b0;
    assign indicator_out_b_oe = s_q.ind_b;
    assign report_busy        = s_q.busy;

endmodule

// ### csr_host.sv
// Host end: issues a request strobe and counts the reply pulses
`timescale 1ns/1ps
module csr_host (
    // Clock and reset
    input  wire logic     ref_clk,
    input  wire logic     rst,
    // Report line
    csr_link_if.host      link,
    // User command and result
    input  wire logic     req_start,
    output logic          busy,
    output logic          done,
    output logic [4:0]    pulse_count
);

    typedef struct packed {
        csr_pkg::csr_hst_st_t st;
        logic [11:0]          cnt;
        logic                 line_q;
        logic [4:0]           count;
        logic [4:0]           result;
        logic                 pull;
        logic                 busy;
        logic                 done;
    } csr_hst_state_t;

    csr_hst_state_t s_q;
    csr_hst_state_t s_d;

    logic fall;

    assign fall = !link.line && s_q.line_q;

    always_comb begin
        s_d        = s_q;
        s_d.line_q = link.line;
        s_d.done   = 1'b0;
        unique case (s_q.st)
            csr_pkg::HST_IDLE: begin
                if (req_start) begin
                    s_d.st    = csr_pkg::HST_STROBE;
                    s_d.cnt   = 12'h000;
                    s_d.count = 5'h00;
                    s_d.pull  = 1'b1;
                    s_d.busy  = 1'b1;
                end
            end
            csr_pkg::HST_STROBE: begin
                // Strobe lasts above the minimum and far below the maximum
                if (s_q.cnt >= csr_pkg::HOST_STROBE_CYC - 12'h001) begin
                    s_d.st   = csr_pkg::HST_LISTEN;
                    s_d.cnt  = 12'h000;
                    s_d.pull = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            csr_pkg::HST_LISTEN: begin
                if (fall) begin
                    s_d.cnt = 12'h000;
                    if (s_q.count != 5'h1f) begin
                        s_d.count = s_q.count + 5'h01;
                    end
                end else if (s_q.cnt >= csr_pkg::HOST_GAP_CYC - 12'h001) begin
                    s_d.st     = csr_pkg::HST_IDLE;
                    s_d.result = s_q.count;
                    s_d.done   = 1'b1;
                    s_d.busy   = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end
            default: begin
                s_d.st   = csr_pkg::HST_IDLE;
                s_d.pull = 1'b0;
                s_d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.host_o  = 1'b0;
    assign link.host_oe = s_q.pull;
    assign busy         = s_q.busy;
    assign done         = s_q.done;
    assign pulse_count  = s_q.result;

endmodule

// ### csr_link_props.sv
// Checker for the report line between device and host ends
`timescale 1ns/1ps
module csr_link_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Report line
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic host_o,
    input wire logic host_oe,
    input wire logic line
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [11:0] hi_q;
    logic [11:0] lo_q;
    logic [11:0] hst_q;
    logic [11:0] rel_q;
    logic [4:0]  np_q;

    // Run lengths of pulses, gaps, strobes and time since release
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hi_q <= 12'h000;
            lo_q <= 12'hfff;
            hst_q <= 12'h000;
            rel_q <= 12'hfff;
            np_q <= 5'h00;
        end else begin
            hi_q <= dev_oe ? hi_q + 12'h001 : 12'h000;
            lo_q <= dev_oe ? 12'h000 : lo_q + 12'(lo_q != 12'hfff);
            hst_q <= host_oe ? hst_q + 12'h001 : 12'h000;
            rel_q <= host_oe ? 12'h000 : rel_q + 12'(rel_q != 12'hfff);
            np_q <= host_oe ? 5'h00 : np_q + 5'(dev_oe && hi_q == 12'h000);
        end
    end

    sequence s_hold_low;
        host_oe [*8];
    endsequence
    sequence s_first_pulse;
        $rose(dev_oe) && rel_q <= 12'h44c;
    endsequence
    sequence s_next_pulse;
        $rose(dev_oe) && rel_q > 12'h44c;
    endsequence

    property p_dev_sink;
        dev_o == 1'b0;
    endproperty
    property p_host_sink;
        host_o == 1'b0;
    endproperty
    property p_idle_high;
        !dev_oe && !host_oe |-> line;
    endproperty
    property p_strobe_min;
        $rose(host_oe) |-> s_hold_low;
    endproperty
    property p_strobe_len;
        $fell(host_oe) |-> hst_q == 12'h032;
    endproperty
    property p_delay;
        s_first_pulse |-> rel_q >= 12'h3de && rel_q <= 12'h3f7;
    endproperty
    property p_gap;
        s_next_pulse |-> lo_q == 12'h064;
    endproperty
    property p_pulse_lo;
        $fell(dev_oe) |-> $past(hi_q) == 12'h063;
    endproperty
    property p_count;
        $rose(host_oe) |-> np_q <= 5'h03 || (np_q >= 5'h0d && np_q <= 5'h17);
    endproperty

    a_dev_sink: assert property (p_dev_sink)
        else $error("device drives the line high");
    a_host_sink: assert property (p_host_sink)
        else $error("host drives the line high");
    a_idle_high: assert property (p_idle_high)
        else $error("released line not high");
    a_strobe_min: assert property (p_strobe_min)
        else $error("request strobe too short");
    a_strobe_len: assert property (p_strobe_len)
        else $error("request strobe length wrong");
    a_delay: assert property (p_delay)
        else $error("reply delay out of range");
    a_gap: assert property (p_gap)
        else $error("reply gap length wrong");
    a_pulse_lo: assert property (p_pulse_lo)
        else $error("reply pulse length wrong");
    a_count: assert property (p_count)
        else $error("reply pulse count not a listed code");
endmodule

// ### charger_status_reporter_tb_top.sv
// Testbench joining device and host ends of the report line
`timescale 1ns/1ps
module charger_status_reporter_tb_top;
    logic       ref_clk;
    logic       rst;
    logic [9:0] cfg;
    logic       req_start;
    logic       busy;
    logic       done;
    logic [4:0] pulse_count;
    logic       ind_a_o;
    logic       ind_a_oe;
    logic       ind_b_o;
    logic       ind_b_oe;
    logic       prev_b;
    logic       dev_busy;
    int         nb = 0;
    int         nb0;
    int         n_fail;
    int         compares;

    csr_link_if link_a ();
    csr_link_if link_b ();

    csr_device #(.FLASH_HALF_CYC(17'h00008)) i_csr_device (
        .ref_clk(ref_clk), .rst(rst), .link(link_a.dev),
        .charge_en(cfg[9]), .supply_ok(cfg[8]), .battery_present(cfg[7]),
        .high_current_setting(cfg[6]), .die_overtemp(cfg[5]),
        .batt_temp_fault(cfg[4]), .over_voltage(cfg[3]),
        .charge_state(cfg[2:0]),
        .indicator_out_a_o(ind_a_o), .indicator_out_a_oe(ind_a_oe),
        .indicator_out_b_o(ind_b_o), .indicator_out_b_oe(ind_b_oe),
        .report_busy(dev_busy));
    csr_device #(.FLASH_HALF_CYC(17'h00008)) i_csr_device_b (
        .ref_clk(ref_clk), .rst(rst), .link(link_b.dev),
        .charge_en(cfg[9]), .supply_ok(cfg[8]), .battery_present(cfg[7]),
        .high_current_setting(cfg[6]), .die_overtemp(cfg[5]),
        .batt_temp_fault(cfg[4]), .over_voltage(cfg[3]),
        .charge_state(cfg[2:0]),
        .indicator_out_a_o(), .indicator_out_a_oe(),
        .indicator_out_b_o(), .indicator_out_b_oe(), .report_busy());
    csr_host i_csr_host (
        .ref_clk(ref_clk), .rst(rst), .link(link_a.host),
        .req_start(req_start), .busy(busy), .done(done),
        .pulse_count(pulse_count));
    csr_link_props i_csr_link_props (
        .ref_clk(ref_clk), .rst(rst), .dev_o(link_a.dev_o),
        .dev_oe(link_a.dev_oe), .host_o(link_a.host_o),
        .host_oe(link_a.host_oe), .line(link_a.line));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Counts reply pulses of the second device
    always @(negedge ref_clk) begin
        if (link_b.dev_oe === 1'b1 && prev_b !== 1'b1) nb++;
        prev_b = link_b.dev_oe;
    end

    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [4:0] got, input logic [4:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic fail_out(input string what);
        n_fail++;
        $display("unexpected at %0t: %s", $time, what);
        final_report();
    endtask

    task automatic read_status(output logic [4:0] got);
        int   i;
        logic seen;
        seen = 1'b0;
        @(posedge ref_clk);
        req_start <= 1'b1;
        @(posedge ref_clk);
        req_start <= 1'b0;
        for (i = 0; i < 8000; i++) begin
            @(negedge ref_clk);
            if (busy === 1'b1 && dev_busy === 1'b1) seen = 1'b1;
            if (done === 1'b1) break;
        end
        if (i == 8000) fail_out("no done from host");
        check({2'b00, seen, busy, dev_busy}, 5'h04, "busy flags");
        got = pulse_count;
    endtask

    // Code 0 means indicators only, no report read
    task automatic run_case(input logic [9:0] c, input logic [4:0] code,
                            input logic [1:0] ind);
        logic [4:0] got;
        @(posedge ref_clk);
        cfg <= c;
        repeat (3) @(negedge ref_clk);
        check({1'b0, ind_a_o, ind_b_o, ind_a_oe, ind_b_oe},
              {3'b000, ind}, "indicators");
        if (code != 5'h00) begin
            read_status(got);
            check(got, code, "report count");
        end
        $display("test done: inputs %h code %0d", c, code);
    endtask

    task automatic strobe_b(input int len);
        @(posedge ref_clk);
        link_b.host_oe <= 1'b1;
        repeat (len) @(posedge ref_clk);
        link_b.host_oe <= 1'b0;
    endtask

    initial begin
        int i;
        int nd;
        int nflip;
        logic pa;
        rst = 1'b1;
        cfg = 10'h000;
        req_start = 1'b0;
        link_b.host_o = 1'b0;
        link_b.host_oe = 1'b0;
        n_fail = 0;
        compares = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        run_case(10'h1c2, 5'h17, 2'b00);
        run_case(10'h2c2, 5'h00, 2'b00);
        for (int h = 0; h < 2; h++) begin
            for (int s = 0; s < 5; s++) begin
                run_case({3'b111, h[0], 3'b000, s[2:0]},
                         5'(h ? 13 + s : 18 + s),
                         (s == 4) ? 2'b01 : 2'b10);
            end
        end
        run_case(10'h3c5, 5'h00, 2'b10);
        run_case(10'h3e2, 5'h01, 2'b11);
        run_case(10'h3d2, 5'h02, 2'b11);
        run_case(10'h3ca, 5'h03, 2'b11);
        run_case(10'h3ea, 5'h01, 2'b11);
        @(posedge ref_clk);
        cfg <= 10'h342;
        @(negedge ref_clk);
        pa = ind_a_oe;
        nd = 0;
        nflip = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge ref_clk);
            if (ind_a_oe !== ind_b_oe) nd++;
            if (ind_a_oe !== pa) nflip++;
            pa = ind_a_oe;
        end
        check(5'(nd != 0), 5'h00, "flash together");
        check(5'(nflip >= 4 && nflip <= 5), 5'h01, "flash rate");
        $display("test done: flashing");
        @(posedge ref_clk);
        cfg <= 10'h3c2;
        nb0 = nb;
        strobe_b(20);
        for (i = 0; i < 1200 && nb == nb0; i++) @(negedge ref_clk);
        if (nb == nb0) fail_out("no reply from second device");
        repeat (150) @(posedge ref_clk);
        link_b.host_oe <= 1'b1;
        repeat (20) @(posedge ref_clk);
        link_b.host_oe <= 1'b0;
        repeat (4000) @(posedge ref_clk);
        check((nb - nb0 > 31) ? 5'h1f : 5'(nb - nb0), 5'h0f,
              "burst with line activity");
        nb0 = nb;
        strobe_b(2100);
        repeat (3000) @(posedge ref_clk);
        check((nb - nb0 > 31) ? 5'h1f : 5'(nb - nb0), 5'h00,
              "overlong strobe");
        $display("test done: second device");
        final_report();
    end

    initial begin
        repeat (98000) @(posedge ref_clk);
        fail_out("run took too long");
    end
endmodule
